// File: common/ccdc_map.vh
// constant map of the clock conditioner dynamic configuration block
//
// Summary of operation
// - conditioner config comes from an 81-bit shift register or static flash switches
// - bit 80 reset enable; 79..77 dynamic selects; 76:74 vco range; 73..71 statics
// - five-bit delays at 70:66..50:46; bit 45 extra delay; 44:40 feedback delay
// - 39:38 feedback source; muxes 37:29; dividers 28:14; fb div 13:7; in div 6:0
// - shift register is reachable from fabric logic, loads streams from the jtag tile
// - new configuration takes effect while the device keeps running, no reprogramming
// - jtag access tile gives fabric bidirectional jtag access without test mode
`ifndef CCDC_MAP_VH
`define CCDC_MAP_VH

// ************
// word layout
// ************
`define CCDC_WIDTH 81
`define CCDC_MSB 80
`define CCDC_RESET_EN 80
`define CCDC_DYN_C 79
`define CCDC_DYN_B 78
`define CCDC_DYN_A 77
`define CCDC_VCO_HI 76
`define CCDC_VCO_LO 74
`define CCDC_STAT_C 73
`define CCDC_STAT_B 72
`define CCDC_STAT_A 71
`define CCDC_SDLY_C_HI 70
`define CCDC_SDLY_C_LO 66
`define CCDC_SDLY_B_HI 65
`define CCDC_SDLY_B_LO 61
`define CCDC_GDLY_C_HI 60
`define CCDC_GDLY_C_LO 56
`define CCDC_GDLY_B_HI 55
`define CCDC_GDLY_B_LO 51
`define CCDC_GDLY_A_HI 50
`define CCDC_GDLY_A_LO 46
`define CCDC_XDLY 45
`define CCDC_FEEDBACK_DELAY_HI 44
`define CCDC_FEEDBACK_DELAY_LO 40
`define CCDC_FBSRC_HI 39
`define CCDC_FBSRC_LO 38
`define CCDC_MUX_C_HI 37
`define CCDC_MUX_C_LO 35
`define CCDC_MUX_B_HI 34
`define CCDC_MUX_B_LO 32
`define CCDC_MUX_A_HI 31
`define CCDC_MUX_A_LO 29
`define CCDC_DIV_C_HI 28
`define CCDC_DIV_C_LO 24
`define CCDC_DIV_B_HI 23
`define CCDC_DIV_B_LO 19
`define CCDC_DIV_A_HI 18
`define CCDC_DIV_A_LO 14
`define CCDC_FEEDBACK_DIVIDER_HI 13
`define CCDC_FEEDBACK_DIVIDER_LO 7
`define CCDC_INDIV_HI 6
`define CCDC_INDIV_LO 0

// ************
// path widths and reset values
// ************
`define CCDC_PATH_W 26
`define CCDC_WORD_RST 81'h0
`define CCDC_PATH_RST 26'h0

// ************
// register bus map
// ************
`define CCDC_A_CTRL 4'h0
`define CCDC_A_SHIFT 4'h1
`define CCDC_A_STAT 4'h2
`define CCDC_A_STATIC 4'h3
`define CCDC_A_CFG0 4'h4
`define CCDC_A_CFG1 4'h5
`define CCDC_A_CFG2 4'h6
`define CCDC_AW 4
`define CCDC_AOFS 2
`define CCDC_CTRL_JTAG 0
`define CCDC_CTRL_UPD 1
`define CCDC_SHIFT_BIT 0
`define CCDC_SHIFT_EN 1
`define CCDC_HTRANS_NSEQ 1
`define CCDC_CNT_W 7
`define CCDC_CFG0_HI 31
`define CCDC_CFG0_LO 0
`define CCDC_CFG1_HI 63
`define CCDC_CFG1_LO 32
`define CCDC_CFG2_LO 64

`endif

// File: hdl/ccdc_path_sel.v
// one output path selector between shifted word and static switches
`timescale 1ns/1ps
module ccdc_path_sel
#(
   parameter W = 26
)
(
   // clock and reset
   input wire clk_i,
   input wire arst_n_i,
   input wire ce_i,
   // selection
   input wire dyn_sel_i,
   input wire [W-1:0] dyn_val_i,
   input wire [W-1:0] stat_val_i,
   // result
   output reg [W-1:0] val_o
);

   // register the chosen path so the output stays glitch free
   always @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         val_o <= {W{1'b0}};
      else if (ce_i)
         val_o <= dyn_sel_i ? dyn_val_i : stat_val_i;
   end

endmodule // ccdc_path_sel

// File: hdl/ccdc_top.v
// dynamic configuration shift register of the clock conditioner
//
// Our own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "ccdc_map.vh"
module ccdc_top
(
   // clock, reset, enable
   input wire clk_i,
   input wire arst_n_i,
   input wire ce_i,
   // ahb-lite slave
   input wire hsel_i,
   input wire [31:0] haddr_i,
   input wire [1:0] htrans_i,
   input wire hwrite_i,
   input wire [2:0] hsize_i,
   input wire [31:0] hwdata_i,
   input wire hready_i,
   output reg [31:0] hrdata_o,
   output reg hreadyout_o,
   output reg hresp_o,
   // jtag access tile (pins from the test domain)
   input wire jtag_shift_en_i,
   input wire jtag_shift_clk_i,
   input wire jtag_tdi_i,
   input wire jtag_update_i,
   output reg jtag_tdo_o,
   // static flash switch settings
   input wire [`CCDC_WIDTH-1:0] static_cfg_i,
   // configuration to the conditioner
   output reg [`CCDC_WIDTH-1:0] cfg_word_o,
   output reg [`CCDC_PATH_W-1:0] path_c_o,
   output reg [`CCDC_PATH_W-1:0] path_b_o,
   output reg [`CCDC_PATH_W-1:0] path_a_o,
   output reg cc_reset_o
);

   // ************
   // declarations
   // ************
   reg [`CCDC_WIDTH-1:0] shift_r;
   reg [`CCDC_WIDTH-1:0] shift_nxt;
   reg [`CCDC_CNT_W-1:0] cnt_r;
   reg en_s1_r;
   reg en_s2_r;
   reg [2:0] ck_s1_r;
   reg [2:0] ck_s2_r;
   reg ck_d_r;
   reg jtag_sel_r;
   reg upd_d_r;
   reg loaded_r;
   reg [`CCDC_AW-1:0] addr_r;
   reg wr_r;
   reg rd_r;
   reg bus_shift_r;
   reg bus_bit_r;
   reg bus_upd_r;
   wire [`CCDC_WIDTH-1:0] w;
   wire jt_shift;
   wire jt_upd;
   wire do_shift;
   wire do_upd;
   wire in_bit;
   wire [`CCDC_PATH_W-1:0] dyn_c, dyn_b, dyn_a, st_c, st_b, st_a;
   wire [`CCDC_PATH_W-1:0] sel_c, sel_b, sel_a;
   wire hit;

   // ************
   // jtag pin synchronisers: en, clk, tdi / update
   // ************
   always @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         ck_s1_r <= 3'h0;
         ck_s2_r <= 3'h0;
         ck_d_r <= 1'b0;
         en_s1_r <= 1'b0;
         en_s2_r <= 1'b0;
      end
      else if (ce_i)
      begin
         ck_s1_r <= {jtag_update_i, jtag_tdi_i, jtag_shift_clk_i};
         ck_s2_r <= ck_s1_r;
         ck_d_r <= ck_s2_r[0];
         en_s1_r <= jtag_shift_en_i;
         en_s2_r <= en_s1_r;
      end
   end

   // fabric sees tdi and shift clock without the device entering test mode
   assign jt_shift = jtag_sel_r & en_s2_r & ck_s2_r[0] & ~ck_d_r;
   assign jt_upd = jtag_sel_r & ck_s2_r[2] & ~upd_d_r;
   assign do_shift = jt_shift | bus_shift_r;
   assign do_upd = jt_upd | bus_upd_r;
   assign in_bit = jtag_sel_r ? ck_s2_r[1] : bus_bit_r;

   // ************
   // bus address and data phase
   // ************
   assign hit = hsel_i & hready_i & htrans_i[`CCDC_HTRANS_NSEQ];

   always @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         addr_r <= `CCDC_A_CTRL;
         wr_r <= 1'b0;
         rd_r <= 1'b0;
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
         hrdata_o <= 32'h0;
         jtag_sel_r <= 1'b0;
         bus_shift_r <= 1'b0;
         bus_bit_r <= 1'b0;
         bus_upd_r <= 1'b0;
      end
      else if (ce_i)
      begin
         addr_r <= haddr_i[`CCDC_AOFS+`CCDC_AW-1:`CCDC_AOFS];
         wr_r <= hit & hwrite_i;
         rd_r <= hit & ~hwrite_i;
         bus_shift_r <= 1'b0;
         bus_upd_r <= 1'b0;
         if (wr_r)
         begin
            // user logic acts as its own tap controller
            case (addr_r)
               `CCDC_A_CTRL:
               begin
                  jtag_sel_r <= hwdata_i[`CCDC_CTRL_JTAG];
                  bus_upd_r <= hwdata_i[`CCDC_CTRL_UPD];
               end
               `CCDC_A_SHIFT:
               begin
                  bus_bit_r <= hwdata_i[`CCDC_SHIFT_BIT];
                  bus_shift_r <= hwdata_i[`CCDC_SHIFT_EN];
               end
               default:
                  bus_bit_r <= bus_bit_r;
            endcase
         end
         if (hit & ~hwrite_i)
         begin
            case (haddr_i[`CCDC_AOFS+`CCDC_AW-1:`CCDC_AOFS])
               `CCDC_A_CTRL: hrdata_o <= {31'h0, jtag_sel_r};
               `CCDC_A_STAT: hrdata_o <= {24'h0, loaded_r, cnt_r};
               `CCDC_A_STATIC: hrdata_o <= {31'h0, w[`CCDC_RESET_EN]};
               `CCDC_A_CFG0: hrdata_o <= cfg_word_o[`CCDC_CFG0_HI:`CCDC_CFG0_LO];
               `CCDC_A_CFG1: hrdata_o <= cfg_word_o[`CCDC_CFG1_HI:`CCDC_CFG1_LO];
               `CCDC_A_CFG2: hrdata_o <= {15'h0, cfg_word_o[`CCDC_MSB:`CCDC_CFG2_LO]};
               default: hrdata_o <= 32'h0;
            endcase
         end
      end
   end

   // ************
   // shift register, msb enters first, lsb last
   // ************
   always @*
   begin
      shift_nxt = shift_r;
      if (do_shift)
         shift_nxt = {shift_r[`CCDC_WIDTH-2:0], in_bit};
   end

   always @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         shift_r <= `CCDC_WORD_RST;
         cnt_r <= {`CCDC_CNT_W{1'b0}};
         upd_d_r <= 1'b0;
         loaded_r <= 1'b0;
         cfg_word_o <= `CCDC_WORD_RST;
         jtag_tdo_o <= 1'b0;
      end
      else if (ce_i)
      begin
         shift_r <= shift_nxt;
         upd_d_r <= ck_s2_r[2];
         jtag_tdo_o <= shift_r[`CCDC_MSB];
         if (do_shift)
            cnt_r <= cnt_r + 7'h1;
         if (do_upd)
         begin
            // whole word lands at once while the device keeps running
            cfg_word_o <= shift_r;
            loaded_r <= 1'b1;
            cnt_r <= {`CCDC_CNT_W{1'b0}};
         end
      end
   end

   assign w = cfg_word_o;

   // ************
   // field slicing, dynamic view and static view
   // ************
   // path = vco, static sel, secondary delay (zeros on path a), global delay, extra delay, mux, divider, 3 pad bits
   assign dyn_c = {w[`CCDC_VCO_HI:`CCDC_VCO_LO], w[`CCDC_STAT_C],
      w[`CCDC_SDLY_C_HI:`CCDC_SDLY_C_LO], w[`CCDC_GDLY_C_HI:`CCDC_GDLY_C_LO],
      w[`CCDC_XDLY], w[`CCDC_MUX_C_HI:`CCDC_MUX_C_LO],
      w[`CCDC_DIV_C_HI:`CCDC_DIV_C_LO], 3'h0};
   assign dyn_b = {w[`CCDC_VCO_HI:`CCDC_VCO_LO], w[`CCDC_STAT_B],
      w[`CCDC_SDLY_B_HI:`CCDC_SDLY_B_LO], w[`CCDC_GDLY_B_HI:`CCDC_GDLY_B_LO],
      w[`CCDC_XDLY], w[`CCDC_MUX_B_HI:`CCDC_MUX_B_LO],
      w[`CCDC_DIV_B_HI:`CCDC_DIV_B_LO], 3'h0};
   assign dyn_a = {w[`CCDC_VCO_HI:`CCDC_VCO_LO], w[`CCDC_STAT_A],
      5'h0, w[`CCDC_GDLY_A_HI:`CCDC_GDLY_A_LO],
      w[`CCDC_XDLY], w[`CCDC_MUX_A_HI:`CCDC_MUX_A_LO],
      w[`CCDC_DIV_A_HI:`CCDC_DIV_A_LO], 3'h0};
   assign st_c = {static_cfg_i[`CCDC_VCO_HI:`CCDC_VCO_LO], static_cfg_i[`CCDC_STAT_C],
      static_cfg_i[`CCDC_SDLY_C_HI:`CCDC_SDLY_C_LO],
      static_cfg_i[`CCDC_GDLY_C_HI:`CCDC_GDLY_C_LO], static_cfg_i[`CCDC_XDLY],
      static_cfg_i[`CCDC_MUX_C_HI:`CCDC_MUX_C_LO],
      static_cfg_i[`CCDC_DIV_C_HI:`CCDC_DIV_C_LO], 3'h0};
   assign st_b = {static_cfg_i[`CCDC_VCO_HI:`CCDC_VCO_LO], static_cfg_i[`CCDC_STAT_B],
      static_cfg_i[`CCDC_SDLY_B_HI:`CCDC_SDLY_B_LO],
      static_cfg_i[`CCDC_GDLY_B_HI:`CCDC_GDLY_B_LO], static_cfg_i[`CCDC_XDLY],
      static_cfg_i[`CCDC_MUX_B_HI:`CCDC_MUX_B_LO],
      static_cfg_i[`CCDC_DIV_B_HI:`CCDC_DIV_B_LO], 3'h0};
   assign st_a = {static_cfg_i[`CCDC_VCO_HI:`CCDC_VCO_LO], static_cfg_i[`CCDC_STAT_A],
      5'h0, static_cfg_i[`CCDC_GDLY_A_HI:`CCDC_GDLY_A_LO], static_cfg_i[`CCDC_XDLY],
      static_cfg_i[`CCDC_MUX_A_HI:`CCDC_MUX_A_LO],
      static_cfg_i[`CCDC_DIV_A_HI:`CCDC_DIV_A_LO], 3'h0};

   // ************
   // per-path dynamic / static choice
   // ************
   ccdc_path_sel #(.W(`CCDC_PATH_W)) u_sel_c
   (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
      .dyn_sel_i(w[`CCDC_DYN_C]), .dyn_val_i(dyn_c), .stat_val_i(st_c), .val_o(sel_c)
   );
   ccdc_path_sel #(.W(`CCDC_PATH_W)) u_sel_b
   (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
      .dyn_sel_i(w[`CCDC_DYN_B]), .dyn_val_i(dyn_b), .stat_val_i(st_b), .val_o(sel_b)
   );
   ccdc_path_sel #(.W(`CCDC_PATH_W)) u_sel_a
   (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
      .dyn_sel_i(w[`CCDC_DYN_A]), .dyn_val_i(dyn_a), .stat_val_i(st_a), .val_o(sel_a)
   );

   // ************
   // output registers
   // ************
   always @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         path_c_o <= `CCDC_PATH_RST;
         path_b_o <= `CCDC_PATH_RST;
         path_a_o <= `CCDC_PATH_RST;
         cc_reset_o <= 1'b0;
      end
      else if (ce_i)
      begin
         path_c_o <= sel_c;
         path_b_o <= sel_b;
         path_a_o <= sel_a;
         cc_reset_o <= w[`CCDC_RESET_EN] & loaded_r;
      end
   end

endmodule // ccdc_top

// File: tb/ccdc_checker.sv
// port checks of the clock conditioner dynamic configuration block
`timescale 1ns/1ps
module ccdc_checker
(
   // clock and reset
   input wire clk_i,
   input wire arst_n_i,
   // bus
   input wire [31:0] haddr_i,
   input wire [1:0] htrans_i,
   input wire hwrite_i,
   input wire hready_i,
   input wire [31:0] hrdata_o,
   input wire hreadyout_o,
   input wire hresp_o,
   // jtag tile and configuration
   input wire jtag_update_i,
   input wire [80:0] static_cfg_i,
   input wire [80:0] cfg_word_o,
   input wire [25:0] path_c_o,
   input wire [25:0] path_a_o,
   input wire cc_reset_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!arst_n_i);
   // read request taken in this address phase
   wire rd_ph = htrans_i[1] && !hwrite_i && hready_i;
   // ************
   // assertions
   // ************
   ready_high_a:
      assert property (hreadyout_o) else $error("slave inserted a wait state");
   resp_okay_a:
      assert property (!hresp_o) else $error("slave gave an error response");
   cfg_low_a:
      assert property (rd_ph && haddr_i[5:2] == 4'h4 |=> !$stable(cfg_word_o)
         || hrdata_o == cfg_word_o[31:0]) else $error("low word read wrong");
   cfg_high_a:
      assert property (rd_ph && haddr_i[5:2] == 4'h6 |=> !$stable(cfg_word_o)
         || hrdata_o[16:0] == cfg_word_o[80:64]) else $error("high word read wrong");
   unmapped_zero_a:
      assert property (rd_ph && haddr_i[5:2] == 4'hF |=> hrdata_o == 32'h0)
         else $error("unmapped read not zero");
   reset_bit_a:
      assert property (cc_reset_o && $stable(cfg_word_o) |-> cfg_word_o[80])
         else $error("reset output without its enable bit");
   dyn_path_c_a:
      assert property ((cfg_word_o[79] && $stable(cfg_word_o)) [*3] |-> $stable(path_c_o))
         else $error("dynamic path c moved");
   stat_path_c_a:
      assert property ((!cfg_word_o[79] && $stable(cfg_word_o) && $stable(static_cfg_i)) [*3]
         |-> $stable(path_c_o)) else $error("static path c moved");
   dyn_path_a_a:
      assert property ((cfg_word_o[77] && $stable(cfg_word_o)) [*3] |-> $stable(path_a_o))
         else $error("dynamic path a moved");
   cfg_hold_a:
      assert property ((!jtag_update_i && htrans_i == 2'h0) [*8] |=> $stable(cfg_word_o))
         else $error("word changed without update");
endmodule // ccdc_checker

// File: tb/ccdc_jtag_model.sv
// user fabric logic model driving the jtag access tile lines
`timescale 1ns/1ps
module ccdc_jtag_model
(
   // clock
   input wire clk_i,
   // jtag tile lines
   output reg shift_en_o,
   output reg shift_clk_o,
   output reg tdi_o,
   output reg update_o
);
   // idle levels, shift clock stands low outside frames
   initial
   begin
      shift_en_o = 1'b0;
      shift_clk_o = 1'b0;
      tdi_o = 1'b0;
      update_o = 1'b0;
   end
   // each level is held four system clocks so the two-flop sync sees it
   task hold;
      repeat (4) @(posedge clk_i);
   endtask
   // shift a word msb first, then strobe the update
   task send(input [80:0] w);
      integer i;
      begin
         shift_en_o <= 1'b1;
         hold;
         for (i = 80; i >= 0; i = i - 1)
         begin
            tdi_o <= w[i];
            hold;
            shift_clk_o <= 1'b1;
            hold;
            shift_clk_o <= 1'b0;
         end
         hold;
         shift_en_o <= 1'b0;
         tdi_o <= ~tdi_o; // released data line shows a changed value
         hold;
         update_o <= 1'b1;
         hold;
         update_o <= 1'b0;
         hold;
      end
   endtask
endmodule // ccdc_jtag_model

// File: tb/ccdc_top_test.sv
// self-checking bench of the clock conditioner dynamic configuration block
`timescale 1ns/1ps
module ccdc_top_test;
   localparam [80:0] W1 = 81'h1_83C5_96E1_0F4B_D287_C3A5;
   localparam [80:0] W2 = 81'h0_75A3_1C6E_F0B4_2D78_5A3C;
   reg clk_i = 1'b0;
   reg arst_n_i = 1'b0;
   reg [1:0] htrans = 2'h0;
   reg [31:0] haddr = 32'h0;
   reg [31:0] hwdata = 32'h0;
   reg hwrite = 1'b0;
   reg [80:0] static_cfg = 81'h0;
   reg ce = 1'b1;
   reg [31:0] rd;
   wire hready, tdo, sen, sclk, tdi, upd, cc_rst;
   wire [31:0] hrdata;
   wire [80:0] cfg;
   wire [25:0] pc, pb, pa;
   integer fail_count = 0;
   integer check_count = 0;
   integer n;
   // ************
   // clock, design, partner
   // ************
   always #5 clk_i = ~clk_i;
   ccdc_top dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce), .hsel_i(1'b1),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
      .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(),
      .jtag_shift_en_i(sen), .jtag_shift_clk_i(sclk), .jtag_tdi_i(tdi), .jtag_update_i(upd),
      .jtag_tdo_o(tdo), .static_cfg_i(static_cfg), .cfg_word_o(cfg), .path_c_o(pc),
      .path_b_o(pb), .path_a_o(pa), .cc_reset_o(cc_rst));
   ccdc_jtag_model jm (.clk_i(clk_i), .shift_en_o(sen), .shift_clk_o(sclk), .tdi_o(tdi),
      .update_o(upd));
   // compare and count
   task check(input [80:0] seen, input [80:0] exp);
      begin
         check_count = check_count + 1;
         if (seen !== exp)
         begin
            fail_count = fail_count + 1;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   // counts and verdict
   task conclude;
      begin
         $display("checks %0d mismatches %0d", check_count, fail_count);
         if (fail_count == 0 && check_count > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   // bounded wait for hready at a rising edge
   task wait_rdy;
      begin
         n = 0;
         @(posedge clk_i);
         while (hready !== 1'b1 && n < 50)
         begin
            n = n + 1;
            @(posedge clk_i);
         end
         if (n == 50)
         begin
            fail_count = fail_count + 1;
            conclude;
         end
      end
   endtask
   // one single ahb-lite word transfer
   task ahb(input wr, input [31:0] a, input [31:0] d);
      begin
         htrans <= 2'h2;
         haddr <= a;
         hwrite <= wr;
         wait_rdy;
         htrans <= 2'h0;
         hwdata <= d;
         wait_rdy;
         rd = hrdata;
      end
   endtask
   // loaded word seen at outputs and through the bus
   task verify(input [80:0] w);
      begin
         repeat (4) @(posedge clk_i);
         check(cfg, w);
         check(cc_rst, w[80]);
         check(tdo, w[80]);
         ahb(1'b0, 32'h10, 32'h0);
         check(rd, w[31:0]);
         ahb(1'b0, 32'h14, 32'h0);
         check(rd, w[63:32]);
         ahb(1'b0, 32'h18, 32'h0);
         check(rd, {15'h0, w[80:64]});
         ahb(1'b0, 32'hC, 32'h0);
         check(rd, {31'h0, w[80]});
         ahb(1'b0, 32'h8, 32'h0);
         check(rd[7:0], 8'h80);
      end
   endtask
   // path c follows the word when dc, path b when db, path a when not dc
   task path_chk(input dc, input db);
      reg [25:0] c0, b0, a0;
      begin
         repeat (4) @(posedge clk_i);
         c0 = pc;
         b0 = pb;
         a0 = pa;
         static_cfg <= ~static_cfg;
         repeat (8) @(posedge clk_i);
         check(pc === c0, dc);
         check(pb === b0, db);
         check(pa === a0, !dc);
      end
   endtask
   // ************
   // scenarios
   // ************
   task reset_test;
      begin
         check(cfg, 81'h0);
         check(cc_rst, 1'b0);
         check(hready, 1'b1);
         ahb(1'b0, 32'h3C, 32'h0);
         check(rd, 32'h0);
         $display("reset test done");
      end
   endtask
   task bus_test;
      integer i;
      begin
         for (i = 80; i >= 0; i = i - 1)
            ahb(1'b1, 32'h4, {30'h0, 1'b1, W1[i]});
         // the last shift lands one cycle after its data phase
         @(posedge clk_i);
         ahb(1'b0, 32'h8, 32'h0);
         check(rd[7:0], 8'h51);
         check(cfg, 81'h0);
         ahb(1'b1, 32'h0, 32'h2);
         verify(W1);
         path_chk(1'b1, 1'b0);
         $display("bus test done");
      end
   endtask
   task jtag_test;
      begin
         ahb(1'b1, 32'h0, 32'h1);
         jm.send(W2);
         verify(W2);
         path_chk(1'b0, 1'b1);
         $display("jtag test done");
      end
   endtask
   // a write while the clock enable is low must leave all state alone
   task freeze_test;
      begin
         ce <= 1'b0;
         ahb(1'b1, 32'h0, 32'h0);
         ce <= 1'b1;
         ahb(1'b0, 32'h0, 32'h0);
         check(rd, 32'h1);
         check(cfg, W2);
         $display("freeze test done");
      end
   endtask
   // main sequence
   initial
   begin
      repeat (3) @(posedge clk_i);
      arst_n_i <= 1'b1;
      reset_test;
      bus_test;
      jtag_test;
      freeze_test;
      conclude;
   end
endmodule // ccdc_top_test
bind ccdc_top ccdc_checker chk (.clk_i, .arst_n_i, .haddr_i, .htrans_i, .hwrite_i, .hready_i,
   .hrdata_o, .hreadyout_o, .hresp_o, .jtag_update_i, .static_cfg_i, .cfg_word_o, .path_c_o,
   .path_a_o, .cc_reset_o);
